// *** msls_pkg.sv ***
// Constants and types for the memory-side latch steering block
// Notes on behaviour
// - Interleave code: 00 four, 01 two, 10 one-way
// - Read latches follow DRAM data while strobe low
// - Strobe rising edge freezes the read latches
// - Host drive enable always wins the internal bus
// - Otherwise memory enable picks memory or system
// - Route asserted: write latch data to DRAM
// - Route deasserted: internal bus straight to DRAM
// - Parity fault is combinational, no register stage
// - Port select picks host or system read mux
// - Parity fault only during main memory reads
// - Even parity, two lines per 16-bit word
// - Port select picks write and read latch set
// - Dword select picks read latch word for bus
package msls_pkg;
   localparam int WORD_W = 16;
   localparam int NWORD = 4;
   localparam int BUS_W = 64;
   localparam int PAR_W = 8;
   localparam int LAT_W = 72;
   localparam int CTL_W = 9;
   // Control vector bit positions
   localparam int C_STB = 0;
   localparam int C_MDRV = 1;
   localparam int C_HDRV = 2;
   localparam int C_WLR = 3;
   localparam int C_HSEL = 4;
   localparam int C_IF = 5;
   localparam int C_SEL = 7;
   // Active-low strobes idle high, port select idles on host
   localparam logic [8:0] CTL_RST = 9'h01F;
   localparam logic [1:0] IF_4WAY = 2'h0;
   localparam logic [1:0] IF_2WAY = 2'h1;
   localparam logic [1:0] IF_1WAY = 2'h2;
   localparam logic [1:0] IF_SYSPORT = 2'h3;
   localparam logic [2:0] WAYS_4 = 3'h4;
   localparam logic [2:0] WAYS_2 = 3'h2;
   localparam logic [2:0] WAYS_1 = 3'h1;
   localparam logic [2:0] WAYS_NONE = 3'h0;
   localparam logic [1:0] FIFO_FULL = 2'h2;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [71:0] LAT_RST = 72'h0;
   typedef enum logic [1:0] {
      OWN_SYS,
      OWN_MEM,
      OWN_HOST
   } msls_owner_e;
endpackage

// *** msls_stream_if.sv ***
// Valid/ready word stream between the steering core and its buffer
`timescale 1ns/1ns
interface msls_stream_if;
   logic valid;
   logic ready;
   logic [15:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** msls_fifo2.sv ***
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ns
module msls_fifo2 (
   input wire logic clk,
   input wire logic rst,
   msls_stream_if.snk wr,
   msls_stream_if.src rd
);
   logic [15:0] mem_ff [2];
   logic [15:0] nxt_mem [2];
   logic wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [1:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign wr.ready = (cnt_ff != msls_pkg::FIFO_FULL);
   assign rd.valid = (cnt_ff != 2'h0);
   assign rd.data = mem_ff[rp_ff];

   always_comb begin
      push = wr.valid && wr.ready;
      pop = rd.valid && rd.ready;
      nxt_mem = mem_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wp_ff] = wr.data;
         nxt_wp = !wp_ff;
      end
      if (pop) begin
         nxt_rp = !rp_ff;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mem_ff[0] <= msls_pkg::WORD_RST;
         mem_ff[1] <= msls_pkg::WORD_RST;
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         mem_ff <= nxt_mem;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_fifo_full;
      (cnt_ff == msls_pkg::FIFO_FULL) && !pop |=> !wr.ready;
   endproperty
   a_fifo_full: assert property (p_fifo_full)
      else $error("buffer accepted a word while full");
endmodule

// *** msls_top.sv ***
// Memory-side read latch, bus ownership and write routing core
`timescale 1ns/1ns
module msls_top (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic MEM_DATA_STROBE_N,
   input wire logic MEM_SIDE_BUS_DRIVE_N,
   input wire logic HOST_SIDE_BUS_DRIVE_N,
   input wire logic WRITE_LATCH_ROUTE_N,
   input wire logic HOST_SYS_SEL,
   input wire logic [1:0] INTERLEAVE_FACTOR,
   input wire logic [1:0] DWORD_SEL,
   input wire logic [63:0] MEM_DATA_IN,
   input wire logic [7:0] DRAM_PARITY_LINES_IN,
   input wire logic [15:0] HOST_BUS_DATA,
   input wire logic [15:0] SYS_BUS_DATA,
   input wire logic HOST_WR_LOAD,
   input wire logic [63:0] HOST_WR_DATA,
   input wire logic SYS_WR_LOAD,
   input wire logic [63:0] SYS_WR_DATA,
   input wire logic RD_WORD_READY,
   output logic [15:0] INT_BUS_DATA,
   output logic [1:0] INT_BUS_OWNER,
   output logic [63:0] MEM_DATA_OUT,
   output logic [7:0] DRAM_PARITY_LINES_OUT,
   output logic MEM_DATA_OE,
   output logic [2:0] ILV_WAYS,
   output logic IF_FAULT,
   output logic PARITY_FAULT_N,
   output logic RD_WORD_VALID,
   output logic [15:0] RD_WORD_DATA,
   output logic WORD_BUF_READY
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [8:0] s1_ff, s2_ff, s3_ff, stab_ff;
   logic [8:0] nxt_stab;
   logic [71:0] din1_ff, din2_ff, din3_ff;

   // A level counts once the second and third stages agree
   always_comb begin
      nxt_stab = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & stab_ff);
   end

   // Data is not synchronised; it is only delayed to line up with
   // the strobe, relying on it standing still while strobed
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s1_ff <= msls_pkg::CTL_RST;
         s2_ff <= msls_pkg::CTL_RST;
         s3_ff <= msls_pkg::CTL_RST;
         stab_ff <= msls_pkg::CTL_RST;
         din1_ff <= msls_pkg::LAT_RST;
         din2_ff <= msls_pkg::LAT_RST;
         din3_ff <= msls_pkg::LAT_RST;
      end else begin
         s1_ff <= {DWORD_SEL, INTERLEAVE_FACTOR, HOST_SYS_SEL,
            WRITE_LATCH_ROUTE_N, HOST_SIDE_BUS_DRIVE_N,
            MEM_SIDE_BUS_DRIVE_N, MEM_DATA_STROBE_N};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         stab_ff <= nxt_stab;
         din1_ff <= {DRAM_PARITY_LINES_IN, MEM_DATA_IN};
         din2_ff <= din1_ff;
         din3_ff <= din2_ff;
      end
   end

   logic stb_hi, mdrv_on, hdrv_on, wlr_on, hs_q;
   logic [1:0] if_q, sel_q;
   assign stb_hi = stab_ff[msls_pkg::C_STB];
   assign mdrv_on = !stab_ff[msls_pkg::C_MDRV];
   assign hdrv_on = !stab_ff[msls_pkg::C_HDRV];
   assign wlr_on = !stab_ff[msls_pkg::C_WLR];
   assign hs_q = stab_ff[msls_pkg::C_HSEL];
   assign if_q = stab_ff[msls_pkg::C_IF +: 2];
   assign sel_q = stab_ff[msls_pkg::C_SEL +: 2];

   // -------------------------------------------------------------
   // Read latches, one set per port (index 1 host, 0 system)
   // -------------------------------------------------------------
   logic [71:0] lat_ff [2];
   logic [71:0] nxt_lat [2];
   logic [1:0] rdv_ff, nxt_rdv;
   logic stb_prev_ff, close;
   logic [71:0] rd_src;

   assign close = stb_hi && !stb_prev_ff;
   assign rd_src = stb_hi ? lat_ff[hs_q] : din3_ff;

   always_comb begin
      nxt_lat = lat_ff;
      nxt_rdv = rdv_ff;
      // Route clears the valid flag, but a read strobe in the same
      // cycle wins; freezing on the rising edge is not loading again
      if (wlr_on) begin
         nxt_rdv[hs_q] = 1'b0;
      end
      if (!stb_hi) begin
         nxt_lat[hs_q] = din3_ff;
         nxt_rdv[hs_q] = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         lat_ff[0] <= msls_pkg::LAT_RST;
         lat_ff[1] <= msls_pkg::LAT_RST;
         rdv_ff <= 2'h0;
         stb_prev_ff <= 1'b1;
      end else begin
         lat_ff <= nxt_lat;
         rdv_ff <= nxt_rdv;
         stb_prev_ff <= stb_hi;
      end
   end

   // -------------------------------------------------------------
   // Read word mux and parity check
   // -------------------------------------------------------------
   logic [15:0] rd_w [4];
   logic [3:0] perr;
   logic rd_act;

   genvar w;
   generate
      for (w = 0; w < msls_pkg::NWORD; w++) begin : g_word
         assign rd_w[w] = rd_src[16*w +: 16];
         assign perr[w] = (^{rd_w[w][7:0], rd_src[64+2*w]}) |
            (^{rd_w[w][15:8], rd_src[65+2*w]});
      end
   endgenerate

   // Only a memory-owned bus with read data counts as a read
   assign rd_act = (!stb_hi || rdv_ff[hs_q]) && !wlr_on &&
      mdrv_on && !hdrv_on;
   // Combinational by intent so the fault meets the read word
   assign PARITY_FAULT_N = !(rd_act && perr[sel_q]);

   // -------------------------------------------------------------
   // Internal bus ownership
   // -------------------------------------------------------------
   msls_pkg::msls_owner_e own_ff, nxt_own;
   logic [15:0] ibus_ff, nxt_ibus;

   always_comb begin
      if (hdrv_on) begin
         nxt_own = msls_pkg::OWN_HOST;
         nxt_ibus = HOST_BUS_DATA;
      end else if (mdrv_on) begin
         nxt_own = msls_pkg::OWN_MEM;
         nxt_ibus = rd_w[sel_q];
      end else begin
         nxt_own = msls_pkg::OWN_SYS;
         nxt_ibus = SYS_BUS_DATA;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         own_ff <= msls_pkg::OWN_SYS;
         ibus_ff <= msls_pkg::WORD_RST;
      end else begin
         own_ff <= nxt_own;
         ibus_ff <= nxt_ibus;
      end
   end

   // -------------------------------------------------------------
   // Write latches and DRAM output path
   // -------------------------------------------------------------
   logic [63:0] wl_ff [2];
   logic [63:0] nxt_wl [2];
   logic [63:0] mout_ff, nxt_mout;
   logic [7:0] mpar_ff, nxt_mpar;
   logic oe_ff, nxt_oe;

   generate
      for (w = 0; w < msls_pkg::PAR_W; w++) begin : g_par
         assign nxt_mpar[w] = ^nxt_mout[8*w +: 8];
      end
   endgenerate

   always_comb begin
      nxt_wl = wl_ff;
      if (HOST_WR_LOAD) begin
         nxt_wl[1] = HOST_WR_DATA;
      end
      if (SYS_WR_LOAD) begin
         nxt_wl[0] = SYS_WR_DATA;
      end
      if (wlr_on) begin
         nxt_mout = wl_ff[hs_q];
      end else begin
         nxt_mout = {4{ibus_ff}};
      end
      // Never drive the DRAM bus while a read is being strobed
      nxt_oe = stb_hi && (own_ff != msls_pkg::OWN_MEM);
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         wl_ff[0] <= 64'h0;
         wl_ff[1] <= 64'h0;
         mout_ff <= 64'h0;
         mpar_ff <= 8'h00;
         oe_ff <= 1'b0;
      end else begin
         wl_ff <= nxt_wl;
         mout_ff <= nxt_mout;
         mpar_ff <= nxt_mpar;
         oe_ff <= nxt_oe;
      end
   end

   // -------------------------------------------------------------
   // Interleave decode
   // -------------------------------------------------------------
   logic [2:0] ways_ff, nxt_ways;
   logic iff_ff, nxt_iff;

   always_comb begin
      unique case (if_q)
         msls_pkg::IF_4WAY: nxt_ways = msls_pkg::WAYS_4;
         msls_pkg::IF_2WAY: nxt_ways = msls_pkg::WAYS_2;
         msls_pkg::IF_1WAY: nxt_ways = msls_pkg::WAYS_1;
         msls_pkg::IF_SYSPORT: nxt_ways = msls_pkg::WAYS_NONE;
      endcase
      // Flags the controller misuse; the cycle itself is undefined
      nxt_iff = !stb_hi && (if_q == msls_pkg::IF_SYSPORT);
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ways_ff <= msls_pkg::WAYS_4;
         iff_ff <= 1'b0;
      end else begin
         ways_ff <= nxt_ways;
         iff_ff <= nxt_iff;
      end
   end

   // -------------------------------------------------------------
   // Captured word stream into the two-entry buffer
   // -------------------------------------------------------------
   msls_stream_if in_if ();
   msls_stream_if out_if ();
   logic pend_ff, nxt_pend;
   logic [15:0] pword_ff, nxt_pword;
   logic bufrdy_ff, nxt_bufrdy;

   // A word held back by a stall waits here; a second close while
   // one waits would overrun, hence the ready output to the source
   assign in_if.valid = pend_ff || close;
   assign in_if.data = pend_ff ? pword_ff : rd_w[sel_q];
   assign out_if.ready = RD_WORD_READY;

   always_comb begin
      nxt_pend = pend_ff;
      nxt_pword = pword_ff;
      if (pend_ff && in_if.ready) begin
         nxt_pend = 1'b0;
      end
      if (close && !pend_ff && !in_if.ready) begin
         nxt_pend = 1'b1;
         nxt_pword = rd_w[sel_q];
      end
      nxt_bufrdy = in_if.ready && !nxt_pend;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pend_ff <= 1'b0;
         pword_ff <= msls_pkg::WORD_RST;
         bufrdy_ff <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
         pword_ff <= nxt_pword;
         bufrdy_ff <= nxt_bufrdy;
      end
   end

   msls_fifo2 u_buf (
      .clk(CLK_SYS),
      .rst(RST),
      .wr(in_if),
      .rd(out_if)
   );

   assign INT_BUS_DATA = ibus_ff;
   assign INT_BUS_OWNER = own_ff;
   assign MEM_DATA_OUT = mout_ff;
   assign DRAM_PARITY_LINES_OUT = mpar_ff;
   assign MEM_DATA_OE = oe_ff;
   assign ILV_WAYS = ways_ff;
   assign IF_FAULT = iff_ff;
   assign RD_WORD_VALID = out_if.valid;
   assign RD_WORD_DATA = out_if.data;
   assign WORD_BUF_READY = bufrdy_ff;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   property p_host_wins;
      hdrv_on |=> INT_BUS_OWNER == msls_pkg::OWN_HOST
         && INT_BUS_DATA == $past(HOST_BUS_DATA);
   endproperty
   a_host_wins: assert property (p_host_wins)
      else $error("host enable did not win the bus");

   property p_mem_owns;
      !hdrv_on && mdrv_on |=> INT_BUS_OWNER == msls_pkg::OWN_MEM
         && INT_BUS_DATA == $past(rd_w[sel_q]);
   endproperty
   a_mem_owns: assert property (p_mem_owns)
      else $error("memory did not own the bus");

   property p_sys_owns;
      !hdrv_on && !mdrv_on |=> INT_BUS_OWNER == msls_pkg::OWN_SYS;
   endproperty
   a_sys_owns: assert property (p_sys_owns)
      else $error("system did not own the bus");

   property p_transparent;
      !stb_hi |=> lat_ff[$past(hs_q)] == $past(din3_ff);
   endproperty
   a_transparent: assert property (p_transparent)
      else $error("read latch not following data");

   property p_frozen;
      stb_hi ##1 stb_hi |-> $stable(lat_ff[0]) && $stable(lat_ff[1]);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("read latch changed while closed");

   property p_route_latch;
      wlr_on |=> MEM_DATA_OUT == $past(wl_ff[hs_q]);
   endproperty
   a_route_latch: assert property (p_route_latch)
      else $error("write latch not routed to DRAM");

   property p_route_bus;
      !wlr_on |=> MEM_DATA_OUT == {4{$past(ibus_ff)}};
   endproperty
   a_route_bus: assert property (p_route_bus)
      else $error("internal bus not routed to DRAM");

   property p_par_read_only;
      !PARITY_FAULT_N |-> mdrv_on && !hdrv_on && !wlr_on;
   endproperty
   a_par_read_only: assert property (p_par_read_only)
      else $error("parity fault outside a memory read");

   property p_par_word;
      rd_act && (^{rd_src[15:0], rd_src[65:64]}) && sel_q == 2'h0
         |-> !PARITY_FAULT_N;
   endproperty
   a_par_word: assert property (p_par_word)
      else $error("word 0 parity fault missed");

   property p_decode;
      if_q == msls_pkg::IF_2WAY |=> ILV_WAYS == msls_pkg::WAYS_2;
   endproperty
   a_decode: assert property (p_decode)
      else $error("interleave code misdecoded");

   property p_no_loss;
      pend_ff && !in_if.ready |=> pend_ff && $stable(pword_ff);
   endproperty
   a_no_loss: assert property (p_no_loss)
      else $error("stalled word lost");

   c_close: cover property (close ##1 RD_WORD_VALID);
   c_perr: cover property (!PARITY_FAULT_N);
   c_stall: cover property (pend_ff ##1 !pend_ff);
   c_route: cover property (wlr_on ##1 !wlr_on);
endmodule

// *** msls_dram_model.sv ***
// Behavioural DRAM controller and array facing the memory side
`timescale 1ns/1ns
module msls_dram_model (
   input wire logic clk,
   output logic mem_data_strobe_n,
   output logic [1:0] ilv,
   output logic [63:0] mem_data,
   output logic [7:0] par
);
   // ---------------------------------------------------------------
   // Idle state
   // ---------------------------------------------------------------
   initial begin
      mem_data_strobe_n = 1'b1;
      ilv = msls_pkg::IF_4WAY;
      mem_data = 64'h0;
      par = 8'hFF;
   end

   // ---------------------------------------------------------------
   // Controller actions, all launched at the falling edge
   // ---------------------------------------------------------------
   task automatic set_ilv(input logic [1:0] code);
      @(negedge clk);
      // The system-port code is never shown while a read is open
      if (!(code === msls_pkg::IF_SYSPORT && mem_data_strobe_n === 1'b0)) begin
         ilv = code;
      end
   endtask

   task automatic start_read(input logic [63:0] d, input logic [7:0] p);
      @(negedge clk);
      mem_data = d;
      par = p;
      // Data is on the bus a cycle before the strobe drops
      @(negedge clk);
      mem_data_strobe_n = 1'b0;
   endtask

   task automatic end_read();
      repeat (2) @(negedge clk);
      mem_data_strobe_n = 1'b1;
      // Hold past the three-flop data delay, then let the bus go
      repeat (4) @(negedge clk);
      // A released bus must not keep showing the captured word
      mem_data = ~mem_data;
      par = ~par;
   endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the memory-side latch steering core
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hdrv_n = 1'b1;
   logic mdrv_n = 1'b1;
   logic route_n = 1'b1;
   logic host_sel = 1'b1;
   logic [1:0] dword_sel = 2'h0;
   logic [15:0] host_bus = 16'hA5C3;
   logic [15:0] sys_bus = 16'h3C5A;
   logic hwr_load = 1'b0;
   logic swr_load = 1'b0;
   logic [63:0] hwr_data = 64'h0;
   logic [63:0] swr_data = 64'h0;
   logic rd_ready = 1'b0;
   logic stb_n;
   logic [1:0] ilv;
   logic [63:0] mem_data;
   logic [7:0] par_in;
   logic [15:0] int_bus_data;
   logic [1:0] owner;
   logic [63:0] mem_out;
   logic [7:0] par_out;
   logic mem_oe;
   logic [2:0] ways;
   logic if_fault;
   logic pfault_n;
   logic rd_valid;
   logic [15:0] rd_data;
   logic buf_ready;
   int tests_run = 0;
   int num_errors = 0;
   int cycles = 0;

   always #50 clk_sys = ~clk_sys;

   msls_dram_model msls_dram_model_inst (
      .clk(clk_sys), .mem_data_strobe_n(stb_n), .ilv(ilv),
      .mem_data(mem_data), .par(par_in));

   msls_top msls_top_inst (
      .CLK_SYS(clk_sys), .RST(rst), .MEM_DATA_STROBE_N(stb_n),
      .MEM_SIDE_BUS_DRIVE_N(mdrv_n), .HOST_SIDE_BUS_DRIVE_N(hdrv_n),
      .WRITE_LATCH_ROUTE_N(route_n), .HOST_SYS_SEL(host_sel),
      .INTERLEAVE_FACTOR(ilv), .DWORD_SEL(dword_sel),
      .MEM_DATA_IN(mem_data), .DRAM_PARITY_LINES_IN(par_in),
      .HOST_BUS_DATA(host_bus), .SYS_BUS_DATA(sys_bus),
      .HOST_WR_LOAD(hwr_load), .HOST_WR_DATA(hwr_data),
      .SYS_WR_LOAD(swr_load), .SYS_WR_DATA(swr_data),
      .RD_WORD_READY(rd_ready), .INT_BUS_DATA(int_bus_data),
      .INT_BUS_OWNER(owner), .MEM_DATA_OUT(mem_out),
      .DRAM_PARITY_LINES_OUT(par_out), .MEM_DATA_OE(mem_oe),
      .ILV_WAYS(ways), .IF_FAULT(if_fault), .PARITY_FAULT_N(pfault_n),
      .RD_WORD_VALID(rd_valid), .RD_WORD_DATA(rd_data),
      .WORD_BUF_READY(buf_ready));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] par_of(input logic [63:0] d);
      for (int i = 0; i < 8; i++) begin
         par_of[i] = ^d[8*i +: 8];
      end
   endfunction

   task automatic results();
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Control pins pass a synchroniser, so results land up to six edges on; settle waits seven
   task automatic settle();
      repeat (7) @(negedge clk_sys);
   endtask

   task automatic pins(input logic hd, input logic md, input logic rt,
                       input logic hs, input logic [1:0] ds);
      @(negedge clk_sys);
      hdrv_n = hd;
      mdrv_n = md;
      route_n = rt;
      host_sel = hs;
      dword_sel = ds;
   endtask

   // Port select and word select stay put for the whole read
   task automatic do_read(input logic hs, input logic [63:0] d,
                          input logic [7:0] p, input logic [1:0] ds);
      pins(1'b1, 1'b0, 1'b1, hs, ds);
      settle();
      msls_dram_model_inst.start_read(d, p);
      settle();
      `CHK(int_bus_data, d[16*ds +: 16])
      msls_dram_model_inst.end_read();
      settle();
      `CHK(int_bus_data, d[16*ds +: 16])
   endtask

   task automatic pop();
      @(negedge clk_sys);
      rd_ready = 1'b1;
      @(negedge clk_sys);
      rd_ready = 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      repeat (12) @(negedge clk_sys);
      `CHK(ways, msls_pkg::WAYS_4)
      `CHK(owner, 2'h0)
      `CHK(mem_out, 64'h0)
      `CHK(rd_valid, 1'b0)
      `CHK(pfault_n, 1'b1)
      rst = 1'b0;
      @(negedge clk_sys);
      `CHK(buf_ready, 1'b1)
   endtask

   task automatic t_owner();
      logic [1:0] eo;
      for (int i = 0; i < 4; i++) begin
         pins(i[1], i[0], 1'b1, 1'b1, 2'h0);
         settle();
         eo = !i[1] ? msls_pkg::OWN_HOST :
              !i[0] ? msls_pkg::OWN_MEM : msls_pkg::OWN_SYS;
         `CHK(owner, eo)
         `CHK(mem_oe, eo !== 2'(msls_pkg::OWN_MEM))
         if (eo !== 2'(msls_pkg::OWN_MEM)) begin
            `CHK(int_bus_data, (i[1] ? sys_bus : host_bus))
         end
      end
   endtask

   task automatic t_ilv();
      logic [2:0] exp_w [4];
      exp_w = '{msls_pkg::WAYS_4, msls_pkg::WAYS_2, msls_pkg::WAYS_1,
                msls_pkg::WAYS_NONE};
      for (int c = 0; c < 4; c++) begin
         msls_dram_model_inst.set_ilv(c[1:0]);
         settle();
         `CHK(ways, exp_w[c])
         `CHK(if_fault, 1'b0)
      end
      msls_dram_model_inst.set_ilv(msls_pkg::IF_4WAY);
   endtask

   // Three words with the consumer stalled, via host, system, then host latch set;
   // the third waits in the hold stage while both entries are full
   task automatic t_buffer();
      logic [63:0] a;
      logic [63:0] b;
      logic [63:0] e;
      a = 64'h1111_2222_3333_4444;
      b = 64'h5555_6666_7777_8888;
      e = 64'h9999_AAAA_BBBB_CCCC;
      do_read(1'b1, a, par_of(a), 2'h2);
      do_read(1'b0, b, par_of(b), 2'h2);
      `CHK(buf_ready, 1'b0)
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, a[47:32])
      pins(1'b1, 1'b0, 1'b1, 1'b1, 2'h2);
      settle();
      `CHK(int_bus_data, a[47:32])
      do_read(1'b1, e, par_of(e), 2'h2);
      `CHK(buf_ready, 1'b0)
      pop();
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, b[47:32])
      pop();
      `CHK(rd_data, e[47:32])
      pop();
      `CHK(rd_valid, 1'b0)
      `CHK(buf_ready, 1'b1)
   endtask

   task automatic t_parity();
      logic [63:0] c;
      logic [7:0] p;
      c = 64'h0F1E_2D3C_4B5A_6978;
      @(negedge clk_sys);
      rd_ready = 1'b1;
      do_read(1'b1, c, par_of(c), 2'h1);
      `CHK(pfault_n, 1'b1)
      for (int w = 0; w < 4; w++) begin
         p = par_of(c) ^ (8'h01 << (2 * w + w % 2));
         do_read(w[0], c, p, w[1:0]);
         `CHK(pfault_n, 1'b0)
         pins(1'b1, 1'b0, 1'b1, w[0], 2'(w + 1));
         settle();
         `CHK(pfault_n, 1'b1)
      end
      do_read(1'b0, c, par_of(c) ^ 8'h04, 2'h1);
      pins(1'b1, 1'b0, 1'b0, 1'b0, 2'h1);
      settle();
      `CHK(pfault_n, 1'b1)
   endtask

   task automatic t_write();
      @(negedge clk_sys);
      hwr_data = 64'hDEAD_BEEF_0123_4567;
      swr_data = 64'hFACE_0FF1_89AB_CDEF;
      hwr_load = 1'b1;
      swr_load = 1'b1;
      @(negedge clk_sys);
      hwr_load = 1'b0;
      swr_load = 1'b0;
      pins(1'b0, 1'b1, 1'b0, 1'b1, 2'h0);
      settle();
      `CHK(mem_out, hwr_data)
      `CHK(par_out, par_of(hwr_data))
      `CHK(mem_oe, 1'b1)
      pins(1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
      settle();
      `CHK(mem_out, swr_data)
      pins(1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
      settle();
      `CHK(mem_out, {4{host_bus}})
      `CHK(par_out, par_of({4{host_bus}}))
   endtask

   // ---------------------------------------------------------------
   // Sequence and hang guard
   // ---------------------------------------------------------------
   initial begin
      t_reset();
      t_owner();
      t_ilv();
      t_buffer();
      t_parity();
      t_write();
      results();
   end

   // The whole sequence needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         results();
      end
   end
endmodule
